// *** inc/prt_pkg.sv ***
// Constants for the prescaled reload timer: offsets, fields, resets, counts.
// Assumes an 8-bit register port with a 6-bit address and read data one cycle later.
// Behaviour
// - The two-bit gate source field picks no gate, the signal input pin, auxiliary pin one or address pin three.
// - The running flag reads 1 whenever the timer is enabled and has no effect on the gate.
// - With auto reload enabled the count restarts from the reload value at the end instead of stopping.
// - With auto reload disabled the count stops at zero and sets the expired interrupt bit.
// - The 12-bit prescale divisor is the mode register's low nibble above the prescale low byte.
// - With even select clear the tick period is twice the divisor plus one clock cycles.
// - With even select set the tick period is twice the divisor plus two clock cycles.
// - The 16-bit reload value is held as two writable bytes, upper and lower.
// - Every start event loads the whole reload value into the counter before counting.
// - Writing a reload byte leaves a running count alone and acts at the next start, or at the next expiry when auto reload is enabled.
// - The live count reads back as two read-only bytes, upper and lower.
// - With protocol auto start set the timer starts at each transmission end, or at RF on when that option is set.
// - With auto start and no multi-frame receive the timer stops after bit 5 in 106k card modes and bit 4 otherwise.
// - With auto start and multi-frame receive the timer ignores received bits and stops only on force stop or, with auto reload disabled, at expiry.
package prt_pkg;
  localparam logic [5:0] PRT_OFS_IRQ_EN = 6'h02;
  localparam logic [5:0] PRT_OFS_IRQ_STAT = 6'h04;
  localparam logic [5:0] PRT_OFS_IRQ_CLR = 6'h05;
  localparam logic [5:0] PRT_OFS_STATUS = 6'h06;
  localparam logic [5:0] PRT_OFS_CONTROL = 6'h0c;
  localparam logic [5:0] PRT_OFS_CONFIG = 6'h0d;
  localparam logic [5:0] PRT_OFS_MODE = 6'h2a;
  localparam logic [5:0] PRT_OFS_PRESCALE = 6'h2b;
  localparam logic [5:0] PRT_OFS_RELOAD_HI = 6'h2c;
  localparam logic [5:0] PRT_OFS_RELOAD_LO = 6'h2d;
  localparam logic [5:0] PRT_OFS_COUNT_HI = 6'h2e;
  localparam logic [5:0] PRT_OFS_COUNT_LO = 6'h2f;
  // Mode register fields
  localparam int PRT_MODE_AUTO_BIT = 7;
  localparam int PRT_MODE_GATE_LSB = 5;
  localparam int PRT_MODE_RELOAD_BIT = 4;
  localparam int PRT_MODE_NIB_LSB = 0;
  // Config register fields
  localparam int PRT_CFG_MULTI_BIT = 7;
  localparam int PRT_CFG_RFON_BIT = 5;
  localparam int PRT_CFG_EVEN_BIT = 4;
  localparam int PRT_CFG_CARD106_BIT = 0;
  // Control register fields
  localparam int PRT_CTL_STOP_BIT = 7;
  localparam int PRT_CTL_START_BIT = 6;
  // Status and interrupt fields
  localparam int PRT_STAT_RUN_BIT = 0;
  localparam int PRT_IRQ_EXP_BIT = 0;
  localparam int PRT_IRQ_START_BIT = 1;
  localparam int PRT_IRQ_W = 2;
  // Reset values
  localparam logic [7:0] PRT_RST_MODE = 8'h00;
  localparam logic [7:0] PRT_RST_PRESCALE = 8'h00;
  localparam logic [7:0] PRT_RST_RELOAD = 8'h00;
  localparam logic [7:0] PRT_RST_CONFIG = 8'h00;
  localparam logic [PRT_IRQ_W-1:0] PRT_RST_IRQ = 2'h0;
  // Received-bit stop counts
  localparam logic [2:0] PRT_RX_STOP_106 = 3'h5;
  localparam logic [2:0] PRT_RX_STOP_OTHER = 3'h4;
  // Gate source codes
  typedef enum logic [1:0] {
    PRT_GATE_NONE = 2'h0,
    PRT_GATE_SIG = 2'h1,
    PRT_GATE_AUX = 2'h2,
    PRT_GATE_ADDR3 = 2'h3
  } prt_gate_t;
endpackage : prt_pkg

// *** core/prt_timer.sv ***
// Prescaled 16-bit reload timer with register port and interrupt.
// Assumes framing events are one-cycle pulses on sys_clk; gate pins are asynchronous.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module prt_timer
  import prt_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRE_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Gate pins
  input wire logic signal_input_pin,
  input wire logic auxiliary_pin_one,
  input wire logic address_pin_three,
  // Framing events
  input wire logic tx_end_pulse,
  input wire logic rf_on_pulse,
  input wire logic rx_bit_pulse,
  // Status out
  output logic timer_running_flag,
  output logic timer_irq
);
  import prt_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] prescale_lower_byte;
  logic [7:0] reload_upper_byte;
  logic [7:0] reload_lower_byte;
  logic [7:0] config_r;
  logic [PRT_IRQ_W-1:0] irq_en_r;
  logic [PRT_IRQ_W-1:0] irq_stat_r;
  logic [7:0] rdata_r;
  logic [CNT_W-1:0] count_r;
  logic [PRE_W:0] pre_cnt_r;
  logic running_r;
  logic [2:0] rx_bits_r;
  logic irq_r;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;

  logic wr_mode, wr_pre, wr_rhi, wr_rlo, wr_cfg, wr_ctl, wr_clr, wr_en;
  logic protocol_auto_start, auto_reload_enable, prescale_even_select;
  logic multi_frame_receive, initial_rf_on_option, card_106_mode;
  logic force_stop_command, soft_start;
  prt_gate_t gate_source_select;
  logic [PRE_W-1:0] prescale_divisor;
  logic [PRE_W:0] div_last;
  logic tick, gate_ok, start_evt, stop_evt, rx_stop, expire;
  logic [CNT_W-1:0] reload_value;
  logic [2:0] rx_limit;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Write decode
  assign wr_mode = reg_wr && hit(reg_addr, PRT_OFS_MODE);
  assign wr_pre = reg_wr && hit(reg_addr, PRT_OFS_PRESCALE);
  assign wr_rhi = reg_wr && hit(reg_addr, PRT_OFS_RELOAD_HI);
  assign wr_rlo = reg_wr && hit(reg_addr, PRT_OFS_RELOAD_LO);
  assign wr_cfg = reg_wr && hit(reg_addr, PRT_OFS_CONFIG);
  assign wr_ctl = reg_wr && hit(reg_addr, PRT_OFS_CONTROL);
  assign wr_clr = reg_wr && hit(reg_addr, PRT_OFS_IRQ_CLR);
  assign wr_en = reg_wr && hit(reg_addr, PRT_OFS_IRQ_EN);

  // Field views
  assign protocol_auto_start = mode_r[PRT_MODE_AUTO_BIT];
  assign gate_source_select = prt_gate_t'(mode_r[PRT_MODE_GATE_LSB +: 2]);
  assign auto_reload_enable = mode_r[PRT_MODE_RELOAD_BIT];
  assign multi_frame_receive = config_r[PRT_CFG_MULTI_BIT];
  assign initial_rf_on_option = config_r[PRT_CFG_RFON_BIT];
  assign prescale_even_select = config_r[PRT_CFG_EVEN_BIT];
  assign card_106_mode = config_r[PRT_CFG_CARD106_BIT];
  assign force_stop_command = wr_ctl && reg_wdata[PRT_CTL_STOP_BIT];
  assign soft_start = wr_ctl && reg_wdata[PRT_CTL_START_BIT];
  assign prescale_divisor = {mode_r[PRT_MODE_NIB_LSB +: 4], prescale_lower_byte};
  assign reload_value = {reload_upper_byte, reload_lower_byte};

  // Tick period minus one: 2P (odd divide) or 2P+1 (even divide)
  assign div_last = {prescale_divisor, prescale_even_select};

  // Config and mode registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_r <= PRT_RST_MODE;
      config_r <= PRT_RST_CONFIG;
    end else begin
      if (wr_mode) begin
        mode_r <= reg_wdata;
      end
      if (wr_cfg) begin
        config_r <= reg_wdata;
      end
    end
  end

  // Prescale and reload bytes; reload bytes reach a running count only at a start event or when it expires with auto reload enabled
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prescale_lower_byte <= PRT_RST_PRESCALE;
      reload_upper_byte <= PRT_RST_RELOAD;
      reload_lower_byte <= PRT_RST_RELOAD;
    end else begin
      if (wr_pre) begin
        prescale_lower_byte <= reg_wdata;
      end
      if (wr_rhi) begin
        reload_upper_byte <= reg_wdata;
      end
      if (wr_rlo) begin
        reload_lower_byte <= reg_wdata;
      end
    end
  end

  // Gate pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {address_pin_three, auxiliary_pin_one, signal_input_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Gate selection
  always_comb begin
    unique case (gate_source_select)
      PRT_GATE_NONE: gate_ok = 1'b1;
      PRT_GATE_SIG: gate_ok = pin_s2_r[0];
      PRT_GATE_AUX: gate_ok = pin_s2_r[1];
      PRT_GATE_ADDR3: gate_ok = pin_s2_r[2];
    endcase
  end

  // Start and stop sources
  assign start_evt = soft_start
    || (protocol_auto_start && (tx_end_pulse || (initial_rf_on_option && rf_on_pulse)));
  assign rx_limit = card_106_mode ? PRT_RX_STOP_106 : PRT_RX_STOP_OTHER;
  assign rx_stop = protocol_auto_start && !multi_frame_receive && running_r
    && rx_bit_pulse && ((rx_bits_r + 3'h1) == rx_limit);
  assign stop_evt = force_stop_command || rx_stop;

  // Prescaler
  assign tick = running_r && (pre_cnt_r == div_last);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_cnt_r <= '0;
    end else if (start_evt || !running_r || tick) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  // Received-bit counter
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_bits_r <= 3'h0;
    end else if (start_evt) begin
      rx_bits_r <= 3'h0;
    end else if (running_r && rx_bit_pulse && rx_bits_r != 3'h7) begin
      rx_bits_r <= rx_bits_r + 3'h1;
    end
  end

  // Counter and running state
  assign expire = tick && gate_ok && (count_r == '0);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_r <= '0;
      running_r <= 1'b0;
    end else if (start_evt) begin
      count_r <= reload_value;
      running_r <= 1'b1;
    end else if (stop_evt) begin
      running_r <= 1'b0;
    end else if (expire) begin
      if (auto_reload_enable) begin
        count_r <= reload_value;
      end else begin
        running_r <= 1'b0;
      end
    end else if (tick && gate_ok) begin
      count_r <= count_r - 1'b1;
    end
  end

  // Interrupt status, enable and level output
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_stat_r <= PRT_RST_IRQ;
    end else begin
      for (int i = 0; i < PRT_IRQ_W; i++) begin
        if ((i == PRT_IRQ_EXP_BIT && expire) || (i == PRT_IRQ_START_BIT && start_evt)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_clr && reg_wdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_en_r <= PRT_RST_IRQ;
    end else if (wr_en) begin
      irq_en_r <= reg_wdata[PRT_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read port
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PRT_OFS_MODE: rdata_r <= mode_r;
        PRT_OFS_PRESCALE: rdata_r <= prescale_lower_byte;
        PRT_OFS_RELOAD_HI: rdata_r <= reload_upper_byte;
        PRT_OFS_RELOAD_LO: rdata_r <= reload_lower_byte;
        PRT_OFS_COUNT_HI: rdata_r <= count_r[15:8];
        PRT_OFS_COUNT_LO: rdata_r <= count_r[7:0];
        PRT_OFS_CONFIG: rdata_r <= config_r;
        PRT_OFS_IRQ_EN: rdata_r <= {6'h00, irq_en_r};
        PRT_OFS_IRQ_STAT: rdata_r <= {6'h00, irq_stat_r};
        PRT_OFS_STATUS: rdata_r <= {7'h00, running_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign timer_irq = irq_r;
  assign timer_running_flag = running_r;
endmodule : prt_timer
`default_nettype wire

// *** verification/prt_timer_chk.sv ***
// Checker for prt_timer port behaviour.
// Assumes it is bound to every prt_timer instance.
`timescale 1ns/1ns
`default_nettype none
module prt_timer_chk
  import prt_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRE_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Framing events
  input wire logic tx_end_pulse,
  input wire logic rf_on_pulse,
  // Status
  input wire logic timer_running_flag,
  input wire logic timer_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic ctl_wr = reg_wr && reg_addr == PRT_OFS_CONTROL;
  wire logic ev = tx_end_pulse || rf_on_pulse;
  wire logic en_wr = reg_wr && reg_addr == PRT_OFS_IRQ_EN;
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_start_runs: assert property (ctl_wr && reg_wdata[PRT_CTL_START_BIT] |=> timer_running_flag)
    else $error("start did not run");
  chk_stop_halts: assert property (ctl_wr && reg_wdata[7:6] == 2'h2 && !ev |=> !timer_running_flag)
    else $error("force stop ignored");
  chk_idle_holds: assert property (!timer_running_flag && !ctl_wr && !ev |=> !timer_running_flag)
    else $error("timer started alone");
  chk_irq_masked: assert property (en_wr && reg_wdata[1:0] == 2'h0 ##1 !en_wr |=> !timer_irq)
    else $error("masked interrupt high");
  chk_status_read: assert property (reg_rd && reg_addr == PRT_OFS_STATUS |=> reg_rdata[0] == $past(timer_running_flag))
    else $error("running bit wrong");
  chk_unmapped_read: assert property (reg_rd && reg_addr == 6'h3f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_clear_read: assert property (reg_rd && reg_addr == PRT_OFS_IRQ_CLR |=> reg_rdata == 8'h00)
    else $error("clear register readable");
  cover property (timer_irq);
  cover property ($fell(timer_running_flag));
  cover property (ctl_wr && reg_wdata[7]);
endmodule : prt_timer_chk
bind prt_timer prt_timer_chk #(.CNT_W(CNT_W), .PRE_W(PRE_W)) i_prt_timer_chk (.sys_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_end_pulse, .rf_on_pulse, .timer_running_flag, .timer_irq);
`default_nettype wire

// *** verification/prt_timer_tb_top.sv ***
// Self-checking bench for prt_timer.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
`default_nettype none
module prt_timer_tb_top;
  import prt_pkg::*;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] e;} prt_row_t;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic signal_input_pin = 0, auxiliary_pin_one = 0, address_pin_three = 0;
  logic tx_end_pulse = 0, rf_on_pulse = 0, rx_bit_pulse = 0, timer_running_flag, timer_irq;
  int err_total = 0, n_compared = 0, cyc = 0, t0;
  prt_row_t rows[8] = '{'{PRT_OFS_PRESCALE, 8'ha5, 8'ha5}, '{PRT_OFS_RELOAD_HI, 8'h5a, 8'h5a},
    '{PRT_OFS_RELOAD_LO, 8'h3c, 8'h3c}, '{PRT_OFS_MODE, 8'h6f, 8'h6f}, '{PRT_OFS_CONFIG, 8'hb1, 8'hb1},
    '{PRT_OFS_COUNT_HI, 8'h77, 8'h00}, '{PRT_OFS_IRQ_CLR, 8'hff, 8'h00}, '{6'h3f, 8'hff, 8'h00}};
  logic [7:0] cf[3] = '{8'h01, 8'h00, 8'h80};
  int nb[3] = '{5, 4, 5};
  prt_timer i_prt_timer (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .signal_input_pin, .auxiliary_pin_one, .address_pin_three, .tx_end_pulse, .rf_on_pulse,
    .rx_bit_pulse, .timer_running_flag, .timer_irq);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic give_verdict();
    $display("TB: compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic run_is(logic e);
    chk("running", {15'h0, e}, {15'h0, timer_running_flag});
  endtask : run_is
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, reg_rdata});
  endtask : rd
  task automatic pulse(int w);
    @(posedge sys_clk);
    {rf_on_pulse, rx_bit_pulse, tx_end_pulse} <= 3'h1 << w;
    @(posedge sys_clk);
    {rf_on_pulse, rx_bit_pulse, tx_end_pulse} <= 3'h0;
    #1;
  endtask : pulse
  task automatic run(logic [7:0] c, logic [7:0] m, logic [7:0] p, int ex);
    wr(PRT_OFS_CONFIG, c);
    wr(PRT_OFS_MODE, m);
    wr(PRT_OFS_PRESCALE, p);
    wr(PRT_OFS_CONTROL, 8'h40);
    #1 t0 = cyc;
    do begin
      @(posedge sys_clk);
      #1;
    end while (timer_running_flag === 1'h1);
    chk("period", 16'(ex), 16'(cyc - t0));
  endtask : run
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'h1;
    #1 run_is(1'h0);
    foreach (rows[i]) begin
      rd(rows[i].a, 8'h00);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(PRT_OFS_RELOAD_HI, 8'h00);
    wr(PRT_OFS_RELOAD_LO, 8'h03);
    wr(PRT_OFS_IRQ_EN, 8'h01);
    run(8'h00, 8'h00, 8'h02, 20);
    @(posedge sys_clk);
    #1 chk("irq", 16'h1, {15'h0, timer_irq});
    wr(PRT_OFS_IRQ_EN, 8'h00);
    @(posedge sys_clk);
    #1 chk("irq", 16'h0, {15'h0, timer_irq});
    rd(PRT_OFS_IRQ_STAT, 8'h03);
    wr(PRT_OFS_IRQ_EN, 8'h01);
    wr(PRT_OFS_IRQ_CLR, 8'h03);
    @(posedge sys_clk);
    #1 chk("irq", 16'h0, {15'h0, timer_irq});
    run(8'h10, 8'h00, 8'h02, 24);
    run(8'h00, 8'h01, 8'h00, 2052);
    wr(PRT_OFS_MODE, 8'h00);
    wr(PRT_OFS_PRESCALE, 8'h02);
    wr(PRT_OFS_RELOAD_HI, 8'h12);
    wr(PRT_OFS_RELOAD_LO, 8'h34);
    wr(PRT_OFS_CONTROL, 8'h40);
    rd(PRT_OFS_COUNT_HI, 8'h12);
    rd(PRT_OFS_COUNT_LO, 8'h34);
    wr(PRT_OFS_RELOAD_HI, 8'h00);
    wr(PRT_OFS_RELOAD_LO, 8'h02);
    rd(PRT_OFS_COUNT_HI, 8'h12);
    wr(PRT_OFS_CONTROL, 8'h40);
    rd(PRT_OFS_COUNT_LO, 8'h02);
    wr(PRT_OFS_MODE, 8'h10);
    wr(PRT_OFS_PRESCALE, 8'h00);
    wr(PRT_OFS_CONTROL, 8'h40);
    repeat (30) @(posedge sys_clk);
    #1 run_is(1'h1);
    wr(PRT_OFS_CONTROL, 8'h80);
    #1 run_is(1'h0);
    wr(PRT_OFS_RELOAD_LO, 8'h05);
    for (int g = 1; g < 4; g++) begin
      wr(PRT_OFS_MODE, 8'(g << PRT_MODE_GATE_LSB));
      {address_pin_three, auxiliary_pin_one, signal_input_pin} <= 3'h7 ^ (3'h1 << (g - 1));
      wr(PRT_OFS_CONTROL, 8'h40);
      repeat (10) @(posedge sys_clk);
      rd(PRT_OFS_COUNT_LO, 8'h05);
      run_is(1'h1);
      {address_pin_three, auxiliary_pin_one, signal_input_pin} <= 3'h7;
      repeat (12) @(posedge sys_clk);
      #1 run_is(1'h0);
    end
    {address_pin_three, auxiliary_pin_one, signal_input_pin} <= 3'h0;
    wr(PRT_OFS_RELOAD_HI, 8'h10);
    wr(PRT_OFS_MODE, 8'h80);
    for (int k = 0; k < 3; k++) begin
      wr(PRT_OFS_CONFIG, cf[k]);
      pulse(0);
      run_is(1'h1);
      repeat (nb[k] - 1) pulse(1);
      run_is(1'h1);
      pulse(1);
      run_is(k == 2);
    end
    wr(PRT_OFS_CONTROL, 8'h80);
    #1 run_is(1'h0);
    wr(PRT_OFS_CONFIG, 8'h20);
    pulse(2);
    run_is(1'h1);
    give_verdict();
  end
endmodule : prt_timer_tb_top
`default_nettype wire
